// >>> logic/breaker_key_params.svh
// How it works
// - password on and no recent command: control key raises password prompt first
// - once the command window lapses, keypad close and open requests are refused
// - select-breaker prompt holds 30 s or until select pressed again
// - second select picks breaker one; then act within 30 s or lapse
// - close key arms close for 20 s; second close issues close command
// - open key arms open for 20 s; second open issues open command
// - each further select press toggles to the other available breaker
// - any non-control key aborts breaker control without a command
// - a lone configured breaker, one or two, is selected by the same key sequence
// - keypad control needs both function enable and keypad enable per breaker
// - three-pole mode takes position from one status input
// - single-pole mode reports position only when all three poles agree
// - numeric settings stored only within own minimum and maximum; increment and decrement move by own step
// - increment adds a step up to maximum, then wraps to minimum
// - decrement subtracts a step down to minimum, then wraps to maximum
// - digits enter most significant first; escape restores original value
// - idle display shows default content, high-priority message preempts it
`ifndef BREAKER_KEY_PARAMS_SVH
`define BREAKER_KEY_PARAMS_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define BKC_CLK_PERIOD_NS 100
`define BKC_SECOND_NS     1000000000
`define BKC_TICK_CYCLES   (`BKC_SECOND_NS / `BKC_CLK_PERIOD_NS)
`define BKC_PERMIT_MIN    30
`define BKC_PERMIT_S      (`BKC_PERMIT_MIN * 60)
`define BKC_PROMPT_S      30
`define BKC_SELECT_S      30
`define BKC_CONFIRM_S     20

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define BKC_DIV_W    24
`define BKC_TMR_W    5
`define BKC_PERMIT_W 11
`define BKC_VAL_W    16

`endif

// >>> logic/breaker_key_pkg.sv
package breaker_key_pkg;
  `include "breaker_key_params.svh"

  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_PASSWORD,
    ST_PROMPT,
    ST_SELECTED,
    ST_ARM_CLOSE,
    ST_ARM_OPEN
  } ctl_state_t;

  typedef struct packed
  {
    ctl_state_t               st;
    logic                     sel;
    logic [`BKC_TMR_W-1:0]    tmr;
    logic [`BKC_PERMIT_W-1:0] permit;
    logic [`BKC_DIV_W-1:0]    div;
    logic                     tick;
    logic [1:0]               close_cmd;
    logic [1:0]               open_cmd;
    logic                     event_show;
    logic                     permit_on;
  } ctl_regs_t;

  typedef struct packed
  {
    logic [`BKC_VAL_W-1:0] val;
    logic [`BKC_VAL_W-1:0] orig;
    logic                  active;
    logic                  entering;
    logic                  reject;
  } edit_regs_t;

  typedef struct packed
  {
    logic closed;
    logic open;
  } pole_regs_t;
endpackage

// >>> logic/pole_position.sv
`timescale 1ns/1ps
`default_nettype none
module pole_position
  import breaker_key_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       resetn_in,
  input  wire logic       single_pole_mode_in,
  input  wire logic [2:0] pole_closed_in,
  output logic            closed_out,
  output logic            open_out
);
  pole_regs_t q;
  pole_regs_t d;

  // ----------------------------------------------------------------------
  // position decode
  // ----------------------------------------------------------------------
  always_comb
  begin
    d = q;
    if (single_pole_mode_in)
    begin
      // disagreeing poles give neither position
      d.closed = &pole_closed_in;
      d.open   = ~|pole_closed_in;
    end
    else
    begin
      d.closed = pole_closed_in[0];
      d.open   = ~pole_closed_in[0];
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      q <= '0;
    else
      q <= d;
  end

  assign closed_out = q.closed;
  assign open_out   = q.open;

  property p_pole_disagree;
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (single_pole_mode_in && !(&pole_closed_in) && |pole_closed_in)
      |=> (!closed_out && !open_out);
  endproperty
  a_pole_disagree: assert property (p_pole_disagree)
    else $error("pole disagreement reported a position");
endmodule
`default_nettype wire

// >>> logic/setting_editor.sv
`timescale 1ns/1ps
`default_nettype none
`include "breaker_key_params.svh"
module setting_editor
  import breaker_key_pkg::*;
(
  input  wire logic                  sys_clk_in,
  input  wire logic                  resetn_in,
  input  wire logic                  load_in,
  input  wire logic [`BKC_VAL_W-1:0] orig_in,
  input  wire logic [`BKC_VAL_W-1:0] min_in,
  input  wire logic [`BKC_VAL_W-1:0] max_in,
  input  wire logic [`BKC_VAL_W-1:0] step_in,
  input  wire logic                  inc_in,
  input  wire logic                  dec_in,
  input  wire logic                  digit_valid_in,
  input  wire logic [3:0]            digit_in,
  input  wire logic                  escape_in,
  input  wire logic                  store_in,
  output logic [`BKC_VAL_W-1:0]      value_out,
  output logic                       active_out,
  output logic                       reject_out
);
  edit_regs_t q;
  edit_regs_t d;
  logic [`BKC_VAL_W:0]   up_sum;
  logic [`BKC_VAL_W:0]   dn_floor;
  logic [`BKC_VAL_W+3:0] shifted;

  // ----------------------------------------------------------------------
  // edit step
  // ----------------------------------------------------------------------
  always_comb
  begin
    d        = q;
    up_sum   = {1'b0, q.val} + {1'b0, step_in};
    dn_floor = {1'b0, min_in} + {1'b0, step_in};
    shifted  = {4'h0, q.val} * 20'h0000A + {16'h0000, digit_in};
    if (load_in)
    begin
      d.val      = orig_in;
      d.orig     = orig_in;
      d.active   = 1'b1;
      d.entering = 1'b0;
      d.reject   = 1'b0;
    end
    else if (q.active)
    begin
      if (escape_in)
      begin
        d.val      = q.orig;
        d.entering = 1'b0;
      end
      else if (digit_valid_in)
      begin
        d.entering = 1'b1;
        // a digit that would overflow the field is dropped
        if (!q.entering)
          d.val = {12'h000, digit_in};
        else if (shifted[`BKC_VAL_W+3:`BKC_VAL_W] == 4'h0)
          d.val = shifted[`BKC_VAL_W-1:0];
      end
      else if (inc_in)
      begin
        if (q.val >= max_in)
          d.val = min_in;
        else if (up_sum > {1'b0, max_in})
          d.val = max_in;
        else
          d.val = up_sum[`BKC_VAL_W-1:0];
      end
      else if (dec_in)
      begin
        if (q.val <= min_in)
          d.val = max_in;
        else if ({1'b0, q.val} < dn_floor)
          d.val = min_in;
        else
          d.val = q.val - step_in;
      end
      else if (store_in)
      begin
        d.entering = 1'b0;
        if (q.val >= min_in && q.val <= max_in)
        begin
          d.orig   = q.val;
          d.active = 1'b0;
          d.reject = 1'b0;
        end
        else
        begin
          d.val    = q.orig;
          d.reject = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      q <= '0;
    else
      q <= d;
  end

  assign value_out  = q.val;
  assign active_out = q.active;
  assign reject_out = q.reject;

  property p_inc_wrap;
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (q.active && !load_in && !escape_in && !digit_valid_in && inc_in
      && q.val == max_in) |=> (value_out == $past(min_in));
  endproperty
  a_inc_wrap: assert property (p_inc_wrap)
    else $error("increment at maximum did not wrap");

  property p_escape_restore;
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (q.active && !load_in && escape_in) |=> (value_out == q.orig);
  endproperty
  a_escape_restore: assert property (p_escape_restore)
    else $error("escape did not restore original value");
endmodule
`default_nettype wire

// >>> logic/breaker_key_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "breaker_key_params.svh"
module breaker_key_control
  import breaker_key_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `BKC_TICK_CYCLES
)
(
  input  wire logic                  sys_clk_in,
  input  wire logic                  resetn_in,
  input  wire logic                  key_select_in,
  input  wire logic                  key_close_in,
  input  wire logic                  key_open_in,
  input  wire logic                  key_other_in,
  input  wire logic                  pwd_enable_in,
  input  wire logic                  pwd_ok_in,
  input  wire logic                  high_prio_msg_in,
  input  wire logic                  first_breaker_func_in,
  input  wire logic                  second_breaker_func_in,
  input  wire logic                  first_breaker_keypad_enable_in,
  input  wire logic                  second_breaker_keypad_enable_in,
  input  wire logic                  first_breaker_single_pole_in,
  input  wire logic [2:0]            first_breaker_pole_in,
  input  wire logic                  second_breaker_single_pole_in,
  input  wire logic [2:0]            second_breaker_pole_in,
  input  wire logic                  edit_load_in,
  input  wire logic [`BKC_VAL_W-1:0] edit_orig_in,
  input  wire logic [`BKC_VAL_W-1:0] edit_min_in,
  input  wire logic [`BKC_VAL_W-1:0] edit_max_in,
  input  wire logic [`BKC_VAL_W-1:0] edit_step_in,
  input  wire logic                  edit_inc_in,
  input  wire logic                  edit_dec_in,
  input  wire logic                  edit_digit_valid_in,
  input  wire logic [3:0]            edit_digit_in,
  input  wire logic                  edit_escape_in,
  input  wire logic                  edit_store_in,
  output ctl_state_t                 display_state_out,
  output logic                       event_show_out,
  output logic                       selected_second_out,
  output logic                       permit_out,
  output logic                       close_first_breaker_out,
  output logic                       open_first_breaker_out,
  output logic                       close_second_breaker_out,
  output logic                       open_second_breaker_out,
  output logic                       first_breaker_closed_out,
  output logic                       first_breaker_open_out,
  output logic                       second_breaker_closed_out,
  output logic                       second_breaker_open_out,
  output logic [`BKC_VAL_W-1:0]      edit_value_out,
  output logic                       edit_active_out,
  output logic                       edit_reject_out
);
  ctl_regs_t  q;
  ctl_regs_t  d;
  logic [1:0] avail;
  logic       ctl_key;
  logic       permit_ok;
  logic       lapse;
  logic [1:0] single_pole;
  logic [2:0] poles [2];
  logic [1:0] pos_closed;
  logic [1:0] pos_open;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // prefer index 0; a lone breaker at index 1 is picked when index 0 is not available
  function automatic logic first_pick(input logic [1:0] av);
    first_pick = av[0] ? 1'b0 : 1'b1;
  endfunction

  // stay on the current breaker when the other one is not available
  function automatic logic other_pick(input logic cur,
                                      input logic [1:0] av);
    other_pick = av[~cur] ? ~cur : cur;
  endfunction

  assign avail[0] = first_breaker_func_in
                    & first_breaker_keypad_enable_in;
  assign avail[1] = second_breaker_func_in
                    & second_breaker_keypad_enable_in;
  assign ctl_key  = key_select_in | key_close_in | key_open_in;
  assign permit_ok = !pwd_enable_in || (q.permit != '0);
  assign lapse    = q.tick && (q.tmr == `BKC_TMR_W'(1));

  // ----------------------------------------------------------------------
  // key sequencer
  // ----------------------------------------------------------------------
  always_comb
  begin
    d           = q;
    d.tick      = 1'b0;
    d.close_cmd = 2'b00;
    d.open_cmd  = 2'b00;
    // one common seconds tick feeds every window
    if (q.div == `BKC_DIV_W'(TICK_CYCLES - 1))
    begin
      d.div  = '0;
      d.tick = 1'b1;
    end
    else
      d.div = q.div + `BKC_DIV_W'(1);
    if (q.tick && q.permit != '0)
      d.permit = q.permit - `BKC_PERMIT_W'(1);
    if (q.tick && q.tmr != '0)
      d.tmr = q.tmr - `BKC_TMR_W'(1);
    case (q.st)
      ST_IDLE:
      begin
        if (ctl_key && avail != 2'b00)
        begin
          if (pwd_enable_in && q.permit == '0)
            d.st = ST_PASSWORD;
          else
          begin
            d.st  = ST_PROMPT;
            d.tmr = `BKC_TMR_W'(`BKC_PROMPT_S);
          end
        end
      end
      ST_PASSWORD:
      begin
        if (pwd_ok_in)
        begin
          d.st     = ST_PROMPT;
          d.tmr    = `BKC_TMR_W'(`BKC_PROMPT_S);
          d.permit = `BKC_PERMIT_W'(`BKC_PERMIT_S);
        end
      end
      ST_PROMPT:
      begin
        if (key_select_in)
        begin
          d.st  = ST_SELECTED;
          d.sel = first_pick(avail);
          d.tmr = `BKC_TMR_W'(`BKC_SELECT_S);
        end
        else if (lapse)
          d.st = ST_IDLE;
      end
      ST_SELECTED:
      begin
        if (key_select_in)
        begin
          d.sel = other_pick(q.sel, avail);
          d.tmr = `BKC_TMR_W'(`BKC_SELECT_S);
        end
        else if (key_close_in)
        begin
          d.st  = ST_ARM_CLOSE;
          d.tmr = `BKC_TMR_W'(`BKC_CONFIRM_S);
        end
        else if (key_open_in)
        begin
          d.st  = ST_ARM_OPEN;
          d.tmr = `BKC_TMR_W'(`BKC_CONFIRM_S);
        end
        else if (lapse)
          d.st = ST_IDLE;
      end
      ST_ARM_CLOSE:
      begin
        if (key_close_in)
        begin
          d.st             = ST_IDLE;
          d.close_cmd[q.sel] = avail[q.sel];
        end
        else if (key_select_in)
        begin
          d.st  = ST_SELECTED;
          d.sel = other_pick(q.sel, avail);
          d.tmr = `BKC_TMR_W'(`BKC_SELECT_S);
        end
        else if (lapse)
          d.st = ST_IDLE;
      end
      ST_ARM_OPEN:
      begin
        if (key_open_in)
        begin
          d.st              = ST_IDLE;
          d.open_cmd[q.sel] = avail[q.sel];
        end
        else if (key_select_in)
        begin
          d.st  = ST_SELECTED;
          d.sel = other_pick(q.sel, avail);
          d.tmr = `BKC_TMR_W'(`BKC_SELECT_S);
        end
        else if (lapse)
          d.st = ST_IDLE;
      end
      default:
        d.st = ST_IDLE;
    endcase
    // an issued command restarts the window so no new password is needed
    if (pwd_enable_in && (d.close_cmd != 2'b00 || d.open_cmd != 2'b00))
      d.permit = `BKC_PERMIT_W'(`BKC_PERMIT_S);
    // window gone mid-sequence: drop out rather than issue anything
    if (!permit_ok && q.st != ST_IDLE && q.st != ST_PASSWORD)
    begin
      d.st        = ST_IDLE;
      d.close_cmd = 2'b00;
      d.open_cmd  = 2'b00;
    end
    if (key_other_in)
    begin
      d.st        = ST_IDLE;
      d.close_cmd = 2'b00;
      d.open_cmd  = 2'b00;
    end
    if (d.st == ST_IDLE)
      d.tmr = '0;
    d.permit_on  = d.permit != '0;
    d.event_show = high_prio_msg_in && (d.st == ST_IDLE);
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      q <= '0;
    else
      q <= d;
  end

  // ----------------------------------------------------------------------
  // position tracking and setting editor
  // ----------------------------------------------------------------------
  assign single_pole[0] = first_breaker_single_pole_in;
  assign single_pole[1] = second_breaker_single_pole_in;
  assign poles[0]       = first_breaker_pole_in;
  assign poles[1]       = second_breaker_pole_in;

  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_pole
      pole_position u_pole
      (
        .sys_clk_in          (sys_clk_in),
        .resetn_in           (resetn_in),
        .single_pole_mode_in (single_pole[i]),
        .pole_closed_in      (poles[i]),
        .closed_out          (pos_closed[i]),
        .open_out            (pos_open[i])
      );
    end
  endgenerate

  setting_editor u_edit
  (
    .sys_clk_in     (sys_clk_in),
    .resetn_in      (resetn_in),
    .load_in        (edit_load_in),
    .orig_in        (edit_orig_in),
    .min_in         (edit_min_in),
    .max_in         (edit_max_in),
    .step_in        (edit_step_in),
    .inc_in         (edit_inc_in),
    .dec_in         (edit_dec_in),
    .digit_valid_in (edit_digit_valid_in),
    .digit_in       (edit_digit_in),
    .escape_in      (edit_escape_in),
    .store_in       (edit_store_in),
    .value_out      (edit_value_out),
    .active_out     (edit_active_out),
    .reject_out     (edit_reject_out)
  );

  assign display_state_out         = q.st;
  assign event_show_out            = q.event_show;
  assign selected_second_out       = q.sel;
  assign permit_out                = q.permit_on;
  assign close_first_breaker_out   = q.close_cmd[0];
  assign close_second_breaker_out  = q.close_cmd[1];
  assign open_first_breaker_out    = q.open_cmd[0];
  assign open_second_breaker_out   = q.open_cmd[1];
  assign first_breaker_closed_out  = pos_closed[0];
  assign first_breaker_open_out    = pos_open[0];
  assign second_breaker_closed_out = pos_closed[1];
  assign second_breaker_open_out   = pos_open[1];

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence s_close_confirm;
    q.st == ST_ARM_CLOSE && key_close_in && !key_other_in && permit_ok;
  endsequence
  sequence s_open_confirm;
    q.st == ST_ARM_OPEN && key_open_in && !key_other_in && permit_ok;
  endsequence

  property p_pwd_first;
    (q.st == ST_IDLE && ctl_key && avail != 2'b00 && pwd_enable_in
      && q.permit == '0 && !key_other_in) |=> (q.st == ST_PASSWORD);
  endproperty
  a_pwd_first: assert property (p_pwd_first)
    else $error("control key skipped the password prompt");

  property p_cmd_permitted;
    (q.close_cmd != 2'b00 || q.open_cmd != 2'b00)
      |-> (!$past(pwd_enable_in) || $past(q.permit) != '0);
  endproperty
  a_cmd_permitted: assert property (p_cmd_permitted)
    else $error("command issued outside the permission window");

  property p_prompt_lapse;
    (q.st == ST_PROMPT && lapse && !key_select_in)
      |=> (q.st == ST_IDLE);
  endproperty
  a_prompt_lapse: assert property (p_prompt_lapse)
    else $error("select prompt outlived its window");

  property p_select_first;
    (q.st == ST_PROMPT && key_select_in && !key_other_in && permit_ok
      && avail[0]) |=> (q.st == ST_SELECTED && !q.sel
      && q.tmr == `BKC_TMR_W'(`BKC_SELECT_S));
  endproperty
  a_select_first: assert property (p_select_first)
    else $error("second select did not pick breaker one");

  property p_close_issue;
    s_close_confirm |=> (q.close_cmd[$past(q.sel)] && q.st == ST_IDLE
      && q.open_cmd == 2'b00) ##1 (q.close_cmd == 2'b00);
  endproperty
  a_close_issue: assert property (p_close_issue)
    else $error("close confirm did not pulse close for selection");
  property p_open_issue;
    s_open_confirm |=> (q.open_cmd[$past(q.sel)] && q.st == ST_IDLE
      && q.close_cmd == 2'b00) ##1 (q.open_cmd == 2'b00);
  endproperty
  a_open_issue: assert property (p_open_issue)
    else $error("open confirm did not pulse open for selection");
  property p_toggle;
    (q.st == ST_SELECTED && key_select_in && !key_other_in && permit_ok
      && avail == 2'b11) |=> (q.sel != $past(q.sel));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("select did not toggle breaker");

  property p_abort;
    key_other_in |=> (q.st == ST_IDLE && q.close_cmd == 2'b00
      && q.open_cmd == 2'b00);
  endproperty
  a_abort: assert property (p_abort)
    else $error("other key did not abort breaker control");

  property p_avail_only;
    (q.close_cmd[1] || q.open_cmd[1]) |-> $past(avail[1]);
  endproperty
  a_avail_only: assert property (p_avail_only)
    else $error("command for a breaker without keypad enable");

  property p_arm_timer;
    (q.st == ST_SELECTED && key_close_in && !key_select_in
      && !key_other_in && permit_ok)
      |=> (q.st == ST_ARM_CLOSE && q.tmr == `BKC_TMR_W'(`BKC_CONFIRM_S));
  endproperty
  a_arm_timer: assert property (p_arm_timer)
    else $error("close arm window not restarted");

  property p_event_show;
    (high_prio_msg_in && q.st == ST_IDLE && !ctl_key) |=> event_show_out;
  endproperty
  a_event_show: assert property (p_event_show)
    else $error("high priority message did not preempt default");
endmodule
`default_nettype wire

// >>> verif/key_operator.sv
`timescale 1ns/1ps
`default_nettype none
module key_operator
(
  input  wire logic sys_clk_in,
  output logic      key_select_out,
  output logic      key_close_out,
  output logic      key_open_out,
  output logic      key_other_out
);
  initial
  begin
    {key_other_out, key_open_out, key_close_out, key_select_out} = 4'h0;
  end
  // one press is a one-cycle pulse launched just after an edge
  task automatic press(input logic [3:0] k);
    @(posedge sys_clk_in);
    #10;
    {key_other_out, key_open_out, key_close_out, key_select_out} = k;
    @(posedge sys_clk_in);
    #10;
    {key_other_out, key_open_out, key_close_out, key_select_out} = 4'h0;
  endtask
endmodule
`default_nettype wire

// >>> verif/breaker_key_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "breaker_key_params.svh"
module breaker_key_control_test;
  import breaker_key_pkg::*;
  localparam logic [3:0] SEL = 4'h1, CLS = 4'h2, OPN = 4'h4, OTH = 4'h8;
  logic sys_clk_in, resetn_in, key_select_in, key_close_in, key_open_in;
  logic key_other_in, pwd_enable_in, pwd_ok_in, high_prio_msg_in;
  logic first_breaker_func_in, second_breaker_func_in;
  logic first_breaker_keypad_enable_in, second_breaker_keypad_enable_in;
  logic first_breaker_single_pole_in, second_breaker_single_pole_in;
  logic [2:0] first_breaker_pole_in, second_breaker_pole_in;
  logic edit_load_in, edit_inc_in, edit_dec_in, edit_digit_valid_in;
  logic edit_escape_in, edit_store_in, edit_active_out, edit_reject_out;
  logic [3:0] edit_digit_in;
  logic [`BKC_VAL_W-1:0] edit_orig_in, edit_min_in, edit_max_in;
  logic [`BKC_VAL_W-1:0] edit_step_in, edit_value_out;
  ctl_state_t display_state_out;
  logic event_show_out, selected_second_out, permit_out;
  logic close_first_breaker_out, open_first_breaker_out;
  logic close_second_breaker_out, open_second_breaker_out;
  logic first_breaker_closed_out, first_breaker_open_out;
  logic second_breaker_closed_out, second_breaker_open_out;
  int err_count, n_tests;

  breaker_key_control #(.TICK_CYCLES(4)) u_breaker_key_control (.*);
  key_operator u_key_operator (.sys_clk_in(sys_clk_in),
    .key_select_out(key_select_in), .key_close_out(key_close_in),
    .key_open_out(key_open_in), .key_other_out(key_other_in));

  initial
  begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #10;
  endtask

  task automatic ed(input logic [5:0] k, input logic [3:0] d);
    cyc(1);
    {edit_store_in, edit_escape_in, edit_digit_valid_in} = k[5:3];
    {edit_dec_in, edit_inc_in, edit_load_in} = k[2:0];
    edit_digit_in = d;
    cyc(1);
    {edit_store_in, edit_escape_in, edit_digit_valid_in} = 3'h0;
    {edit_dec_in, edit_inc_in, edit_load_in} = 3'h0;
  endtask

  // a hang in any wait ends the run as a mismatch
  initial
  begin
    #1ms;
    err_count++;
    wrap_up();
  end

  initial
  begin
    err_count = 0;
    n_tests = 0;
    void'($urandom(90));
    {resetn_in, pwd_enable_in, pwd_ok_in, high_prio_msg_in} = 4'h0;
    {first_breaker_func_in, second_breaker_func_in} = 2'h3;
    {first_breaker_keypad_enable_in, second_breaker_keypad_enable_in} = 2'h3;
    {first_breaker_single_pole_in, second_breaker_single_pole_in} = 2'h0;
    {first_breaker_pole_in, second_breaker_pole_in} = 6'h00;
    {edit_load_in, edit_inc_in, edit_dec_in, edit_digit_valid_in} = 4'h0;
    {edit_escape_in, edit_store_in, edit_digit_in} = 6'h00;
    edit_orig_in = 16'h0014;
    edit_min_in = 16'h0005;
    edit_max_in = 16'h0014;
    edit_step_in = 16'h0005;
    cyc(20);
    resetn_in = 1'b1;
    cyc(2);
    u_key_operator.press(SEL);
    chk(16'(display_state_out), 16'(ST_PROMPT));
    u_key_operator.press(SEL);
    chk(16'(display_state_out), 16'(ST_SELECTED));
    chk(16'(selected_second_out), 16'h0000);
    u_key_operator.press(CLS);
    chk(16'(display_state_out), 16'(ST_ARM_CLOSE));
    u_key_operator.press(CLS);
    chk(16'(close_first_breaker_out), 16'h0001);
    chk(16'(close_second_breaker_out), 16'h0000);
    for (int i = 0; i < 3; i++) u_key_operator.press(SEL);
    chk(16'(selected_second_out), 16'h0001);
    u_key_operator.press(OPN);
    u_key_operator.press(OPN);
    chk(16'(open_second_breaker_out), 16'h0001);
    chk(16'(open_first_breaker_out), 16'h0000);
    u_key_operator.press(SEL);
    u_key_operator.press(OTH);
    chk(16'(display_state_out), 16'(ST_IDLE));
    second_breaker_keypad_enable_in = 1'b0;
    for (int i = 0; i < 3; i++) u_key_operator.press(SEL);
    chk(16'(selected_second_out), 16'h0000);
    u_key_operator.press(OPN);
    u_key_operator.press(OPN);
    chk(16'(open_first_breaker_out), 16'h0001);
    first_breaker_keypad_enable_in = 1'b0;
    u_key_operator.press(SEL);
    chk(16'(display_state_out), 16'(ST_IDLE));
    {first_breaker_keypad_enable_in, second_breaker_keypad_enable_in} = 2'h3;
    u_key_operator.press(SEL);
    cyc(100);
    chk(16'(display_state_out), 16'(ST_PROMPT));
    cyc(30);
    chk(16'(display_state_out), 16'(ST_IDLE));
    pwd_enable_in = 1'b1;
    u_key_operator.press(CLS);
    chk(16'(display_state_out), 16'(ST_PASSWORD));
    pwd_ok_in = 1'b1;
    cyc(1);
    pwd_ok_in = 1'b0;
    chk(16'(permit_out), 16'h0001);
    pwd_enable_in = 1'b0;
    u_key_operator.press(OTH);
    high_prio_msg_in = 1'b1;
    cyc(2);
    chk(16'(event_show_out), 16'h0001);
    ed(6'h01, 4'h0);
    ed(6'h02, 4'h0);
    chk(edit_value_out, 16'h0005);
    ed(6'h04, 4'h0);
    chk(edit_value_out, 16'h0014);
    ed(6'h08, 4'h1);
    ed(6'h08, 4'h2);
    chk(edit_value_out, 16'h000C);
    ed(6'h10, 4'h0);
    chk(edit_value_out, 16'h0014);
    ed(6'h08, 4'h9);
    ed(6'h08, 4'h9);
    chk(edit_value_out, 16'h0063);
    ed(6'h20, 4'h0);
    chk(16'({edit_reject_out, edit_active_out}), 16'h0003);
    chk(edit_value_out, 16'h0014);
    ed(6'h20, 4'h0);
    chk(16'({edit_reject_out, edit_active_out}), 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      first_breaker_pole_in = 3'($urandom);
      second_breaker_pole_in = 3'($urandom);
      first_breaker_single_pole_in = i[0];
      second_breaker_single_pole_in = ~i[0];
      cyc(2);
      chk({first_breaker_closed_out, first_breaker_open_out},
        i[0] ? {&first_breaker_pole_in, ~|first_breaker_pole_in}
             : {first_breaker_pole_in[0], ~first_breaker_pole_in[0]});
      chk({second_breaker_closed_out, second_breaker_open_out},
        i[0] ? {second_breaker_pole_in[0], ~second_breaker_pole_in[0]}
             : {&second_breaker_pole_in, ~|second_breaker_pole_in});
    end
    wrap_up();
  end
endmodule
`default_nettype wire
